// File: src/frpw_defines.vh
`ifndef FRPW_DEFINES_VH
`define FRPW_DEFINES_VH
`define FRPW_MODE_FREE_RUN  3'h5
`define FRPW_MODE_PULSE_W   3'h6
`define FRPW_CNT_MAX        16'hFFFF
`define FRPW_CNT_ZERO       16'h0000
`define FRPW_EDGE_NONE      2'h0
`define FRPW_EDGE_RISE      2'h1
`define FRPW_EDGE_FALL      2'h2
`define FRPW_EDGE_BOTH      2'h3
`define FRPW_OPT_WRAP_BIT   0
`define FRPW_OPT_FS0_BIT    4
`define FRPW_OPT_FS1_BIT    5
`define FRPW_CCR_RESET      16'h0000
`endif

// File: src/frpw_edge_detect.v
`timescale 1ns/100ps
`include "frpw_defines.vh"
module frpw_edge_detect (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       pin_in,
  input  wire [1:0] edge_sel,
  output reg        edge_hit
);
  reg prev_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      edge_hit <= 1'b0;
    end else begin
      prev_reg <= pin_in;
      case (edge_sel)
        `FRPW_EDGE_RISE: edge_hit <= pin_in & ~prev_reg;
        `FRPW_EDGE_FALL: edge_hit <= ~pin_in & prev_reg;
        `FRPW_EDGE_BOTH: edge_hit <= pin_in ^ prev_reg;
        default:         edge_hit <= 1'b0;
      endcase
    end
  end
endmodule // frpw_edge_detect

// File: src/frpw_capture.v
`timescale 1ns/100ps
`include "frpw_defines.vh"
// Behaviour
// - Mode field 110 selects pulse width measurement.
// - Pulse mode: valid edge stores count and clears counter to zero.
// - Pulse mode capture raises that input's channel interrupt.
// - At FFFF without capture, next count clock pulses overflow, wraps, continues.
// - Every wrap sets sticky overflow flag until software clears it.
// - Flag cleared by bit clear or byte write with bit 0 zero.
// - Overflow set wins over a simultaneous clear.
// - Free-running: both capture/compare registers act independently.
// - Mode field 101 selects free-running; counting starts with run bit.
// - Function select bits choose compare or capture per channel.
// - Compare match raises channel interrupt and toggles output pin.
// - Free-running capture stores count, raises interrupt, keeps counting.
module frpw_capture (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        count_en,
  input  wire        count_run_bit,
  input  wire [2:0]  op_mode_field,
  input  wire [7:0]  option_wdata,
  input  wire        option_byte_wr,
  input  wire        bit_clear_op,
  input  wire [1:0]  edge_sel_zero,
  input  wire [1:0]  edge_sel_one,
  input  wire        capture_input_zero,
  input  wire        capture_input_one,
  input  wire        ccr0_wr,
  input  wire        ccr1_wr,
  input  wire [15:0] ccr_wdata,
  output reg  [15:0] capture_compare_reg_zero,
  output reg  [15:0] capture_compare_reg_one,
  output reg  [15:0] count_value,
  output reg         wrap_flag,
  output reg         chan0_function_select,
  output reg         chan1_function_select,
  output reg         channel_event_irq_zero,
  output reg         channel_event_irq_one,
  output reg         wrap_irq,
  output reg         timer_output_pin_zero,
  output reg         timer_output_pin_one
);
  wire hit0;
  wire hit1;
  reg  run_q_reg;

  frpw_edge_detect u_edge0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   (capture_input_zero),
    .edge_sel (edge_sel_zero),
    .edge_hit (hit0)
  );

  frpw_edge_detect u_edge1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   (capture_input_one),
    .edge_sel (edge_sel_one),
    .edge_hit (hit1)
  );

  // Equality of the counter with a reference, shared by match and wrap logic.
  function count_equals;
    input [15:0] cnt;
    input [15:0] ref_val;
    begin
      count_equals = (cnt == ref_val);
    end
  endfunction

  // A channel captures always in pulse mode, in free-run only when set for capture.
  function capture_gate;
    input act;
    input hit;
    input pw;
    input fsel;
    begin
      capture_gate = act & hit & (pw | fsel);
    end
  endfunction

  // A channel matches only in free-run, when set for compare, on a count enable.
  function match_gate;
    input        tk;
    input        fr;
    input        fsel;
    input [15:0] cnt;
    input [15:0] val;
    begin
      match_gate = tk & fr & ~fsel & count_equals(cnt, val);
    end
  endfunction

  wire mode_pw = (op_mode_field == `FRPW_MODE_PULSE_W);
  wire mode_fr = (op_mode_field == `FRPW_MODE_FREE_RUN);
  wire active  = count_run_bit & (mode_pw | mode_fr);
  wire start   = active & ~run_q_reg;
  wire tick    = active & count_en;
  wire cap0     = capture_gate(active, hit0, mode_pw, chan0_function_select);
  wire cap1     = capture_gate(active, hit1, mode_pw, chan1_function_select);
  wire pw_clear = mode_pw & (cap0 | cap1);
  wire cmp0 = match_gate(tick, mode_fr, chan0_function_select, count_value, capture_compare_reg_zero);
  wire cmp1 = match_gate(tick, mode_fr, chan1_function_select, count_value, capture_compare_reg_one);
  wire wrap = tick & count_equals(count_value, `FRPW_CNT_MAX) & ~pw_clear;
  wire clr = bit_clear_op | (option_byte_wr & ~option_wdata[`FRPW_OPT_WRAP_BIT]);

  reg  [15:0] count_next;
  reg  [15:0] ccr0_next;
  reg  [15:0] ccr1_next;
  reg         flag_next;
  reg         fs0_next;
  reg         fs1_next;
  reg         out0_next;
  reg         out1_next;

  always @* begin
    count_next = count_value;
    if (!active) begin
      count_next = `FRPW_CNT_ZERO;
    end else if (pw_clear) begin
      count_next = `FRPW_CNT_ZERO;
    end else if (tick) begin
      count_next = count_value + 16'h0001;
    end
  end

  always @* begin
    ccr0_next = capture_compare_reg_zero;
    if (cap0) begin
      ccr0_next = count_value;
    end else if (ccr0_wr) begin
      ccr0_next = ccr_wdata;
    end
  end

  always @* begin
    ccr1_next = capture_compare_reg_one;
    if (cap1) begin
      ccr1_next = count_value;
    end else if (ccr1_wr) begin
      ccr1_next = ccr_wdata;
    end
  end

  always @* begin
    flag_next = wrap_flag;
    if (wrap) begin
      flag_next = 1'b1;
    end else if (clr) begin
      flag_next = 1'b0;
    end
  end

  always @* begin
    fs0_next = chan0_function_select;
    fs1_next = chan1_function_select;
    if (option_byte_wr) begin
      fs0_next = option_wdata[`FRPW_OPT_FS0_BIT];
      fs1_next = option_wdata[`FRPW_OPT_FS1_BIT];
    end
  end

  // Outputs invert at a free-run start and on each compare match.
  // toggle output pin
  always @* begin
    out0_next = timer_output_pin_zero ^ ((start & mode_fr) | cmp0);
    out1_next = timer_output_pin_one ^ ((start & mode_fr) | cmp1);
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q_reg                <= 1'b0;
      count_value              <= `FRPW_CNT_ZERO;
      capture_compare_reg_zero <= `FRPW_CCR_RESET;
      capture_compare_reg_one  <= `FRPW_CCR_RESET;
      wrap_flag                <= 1'b0;
      chan0_function_select    <= 1'b0;
      chan1_function_select    <= 1'b0;
      channel_event_irq_zero   <= 1'b0;
      channel_event_irq_one    <= 1'b0;
      wrap_irq                 <= 1'b0;
      timer_output_pin_zero    <= 1'b0;
      timer_output_pin_one     <= 1'b0;
    end else begin
      run_q_reg                <= active;
      chan0_function_select    <= fs0_next;
      chan1_function_select    <= fs1_next;
      count_value              <= count_next;
      capture_compare_reg_zero <= ccr0_next;
      capture_compare_reg_one  <= ccr1_next;
      wrap_flag                <= flag_next;
      timer_output_pin_zero    <= out0_next;
      timer_output_pin_one     <= out1_next;
      channel_event_irq_zero <= cap0 | cmp0;
      channel_event_irq_one  <= cap1 | cmp1;
      wrap_irq               <= wrap;
    end
  end
endmodule // frpw_capture

// File: tb/frpw_capture_sva.sv
`timescale 1ns/100ps
module frpw_capture_sva (
  input wire        clk,
  input wire        rst_n,
  input wire        count_en,
  input wire        count_run_bit,
  input wire [2:0]  op_mode_field,
  input wire [7:0]  option_wdata,
  input wire        option_byte_wr,
  input wire        bit_clear_op,
  input wire [15:0] count_value,
  input wire        wrap_flag,
  input wire        wrap_irq,
  input wire        channel_event_irq_zero
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire act = count_run_bit && (op_mode_field == 3'h5 || op_mode_field == 3'h6);
  wire top = count_en && count_value == 16'hFFFF;
  a_wrap_cause: assert property (act && op_mode_field == 3'h5 && top |=> wrap_irq) else $error("no wrap");
  a_wrap_state: assert property (wrap_irq |-> count_value == 16'h0000 && wrap_flag) else $error("bad wrap");
  a_wrap_pulse: assert property (wrap_irq |=> !wrap_irq) else $error("long wrap irq");
  a_flag_hold: assert property (wrap_flag && !bit_clear_op && !option_byte_wr |=> wrap_flag) else $error("lost");
  a_bit_clear: assert property (bit_clear_op && !top |=> !wrap_flag) else $error("bit clear");
  a_byte_clear: assert property (option_byte_wr && !option_wdata[0] && !top |=> !wrap_flag) else $error("byte");
  a_idle_zero: assert property (!act |=> count_value == 16'h0000) else $error("idle count");
  a_pulse_clear: assert property (op_mode_field == 3'h6 && channel_event_irq_zero |-> count_value == 16'h0000) else $error("clr");
endmodule // frpw_capture_sva

// File: tb/frpw_pins.sv
`timescale 1ns/100ps
module frpw_pins (
  input  wire       clk,
  input  wire       en,
  input  wire       sel,
  input  wire [7:0] half,
  output reg        pin_zero = 1'b0,
  output reg        pin_one = 1'b0
);
  reg  [7:0] cnt_reg = 8'h00;
  wire       flip = en && cnt_reg == half - 8'h01;
  always @(posedge clk) begin
    cnt_reg <= (en && !flip) ? cnt_reg + 8'h01 : 8'h00;
    if (flip && sel) pin_one <= !pin_one;
    if (flip && !sel) pin_zero <= !pin_zero;
  end
endmodule // frpw_pins

// File: tb/frpw_capture_tb.sv
`timescale 1ns/100ps
bind frpw_capture frpw_capture_sva frpw_capture_sva_inst (.clk, .rst_n, .count_en, .count_run_bit, .op_mode_field,
  .option_wdata, .option_byte_wr, .bit_clear_op, .count_value, .wrap_flag, .wrap_irq, .channel_event_irq_zero);
module frpw_capture_tb;
  reg         clk = 0, rst_n = 0, count_en = 0, count_run_bit = 0, option_byte_wr = 0, bit_clear_op = 0;
  reg         ccr0_wr = 0, ccr1_wr = 0, p_en = 0, p_sel = 0;
  reg  [2:0]  op_mode_field = 0;
  reg  [7:0]  option_wdata = 0, p_half = 1;
  reg  [1:0]  edge_sel_zero = 0, edge_sel_one = 0;
  reg  [15:0] ccr_wdata = 0;
  wire [15:0] capture_compare_reg_zero, capture_compare_reg_one, count_value;
  wire        wrap_flag, chan0_function_select, chan1_function_select, channel_event_irq_zero;
  wire        channel_event_irq_one, wrap_irq, timer_output_pin_zero, timer_output_pin_one;
  wire        capture_input_zero, capture_input_one;
  wire [2:0]  irqs = {wrap_irq, channel_event_irq_one, channel_event_irq_zero};
  integer     n_fail = 0, checks = 0;
  integer     now_cyc = 0, t0 = 0, t1 = 0, sw_wrap_record_one = 0, sw_width = 0;
  reg  [15:0] cap_prev = 0;
  always @(posedge clk) now_cyc <= now_cyc + 1;
  always #10 clk = ~clk;
  frpw_pins frpw_pins_inst (.clk(clk), .en(p_en), .sel(p_sel), .half(p_half), .pin_zero(capture_input_zero),
    .pin_one(capture_input_one));
  frpw_capture frpw_capture_inst (.clk, .rst_n, .count_en, .count_run_bit, .op_mode_field, .option_wdata,
    .option_byte_wr, .bit_clear_op, .edge_sel_zero, .edge_sel_one, .capture_input_zero, .capture_input_one,
    .ccr0_wr, .ccr1_wr, .ccr_wdata, .capture_compare_reg_zero, .capture_compare_reg_one, .count_value,
    .wrap_flag, .chan0_function_select, .chan1_function_select, .channel_event_irq_zero,
    .channel_event_irq_one, .wrap_irq, .timer_output_pin_zero, .timer_output_pin_one);
  task check(input [15:0] seen, input [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wt(input integer w);
    integer k;
    k = 0;
    do begin
      @(negedge clk);
      k = k + 1;
    end while (k < 70000 && irqs[w] !== 1'b1);
    if (irqs[w] !== 1'b1) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1;
    check(count_value, 16'h0000);
    ccr0_wr = 1; ccr_wdata = 16'h0009; option_byte_wr = 1; option_wdata = 8'h20; edge_sel_one = 2'h1;
    @(negedge clk) ccr0_wr = 0; option_byte_wr = 0; op_mode_field = 3'h5; count_run_bit = 1; count_en = 1;
    @(negedge clk) check(chan1_function_select, 16'h0001);
    check(chan0_function_select, 16'h0000);
    wt(0);
    check(timer_output_pin_zero, 16'h0000);
    check(timer_output_pin_one, 16'h0001);
    check(count_value, 16'h000A);
    ccr0_wr = 1;
    ccr_wdata = 16'h0013;
    @(negedge clk) ccr0_wr = 0;
    wt(0);
    check(count_value, 16'h0014);
    p_sel = 1; p_half = 8; p_en = 1;
    wt(1);
    check(capture_compare_reg_one, 16'h001D);
    check(capture_compare_reg_zero, 16'h0013);
    check(count_value, 16'h001E);
    cap_prev = capture_compare_reg_one;
    wt(1);
    p_en = 0;
    check(capture_compare_reg_one - cap_prev, 16'h0010);
    cap_prev = capture_compare_reg_one;
    t0 = now_cyc;
    wt(2);
    sw_wrap_record_one = sw_wrap_record_one + 1;
    check(wrap_flag, 16'h0001);
    bit_clear_op = 1;
    @(negedge clk) bit_clear_op = 0;
    check(wrap_flag, 16'h0000);
    p_en = 1;
    wt(1);
    t1 = now_cyc;
    p_en = 0;
    sw_width = sw_wrap_record_one * 65536 + capture_compare_reg_one - cap_prev;
    check(sw_width == t1 - t0, 16'h0001);
    count_run_bit = 0; op_mode_field = 3'h6; edge_sel_one = 2'h0; edge_sel_zero = 2'h1;
    @(negedge clk) count_run_bit = 1; p_sel = 0; p_half = 6; p_en = 1;
    wt(0);
    wt(0);
    check(capture_compare_reg_zero, 16'h000B);
    check(channel_event_irq_one, 16'h0000);
    p_en = 0;
    count_run_bit = 0;
    edge_sel_zero = 2'h0;
    edge_sel_one = 2'h1;
    @(negedge clk) count_run_bit = 1; p_sel = 1; p_en = 1;
    wt(1);
    wt(1);
    check(capture_compare_reg_one, 16'h000B);
    check(channel_event_irq_zero, 16'h0000);
    complete_run;
  end
endmodule // frpw_capture_tb
